/* verilog/trig_params.svh */
// Constants for the trigger debounce and sequence capture block
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH

// Clock and time base
`define CLK_PERIOD_NS 50
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)

// Programmable limits in microseconds
`define DEBOUNCE_MAX_US 20000
`define DELAY_MAX_US 5000000

// Field widths
`define DBC_W 15
`define DLY_W 23
`define BURST_W 8
`define TBL_AW 4
`define TBL_DEPTH 16
`define EXP_W 24
`define GAIN_W 16
`define PRE_W 8

// Trigger source selector codes
`define SRC_ISO 2'h0
`define SRC_GL0 2'h1
`define SRC_GL1 2'h2

// Reset values
`define IDX_RST 4'h0
`define DBC_CNT_RST 15'h0000
`define DLY_CNT_RST 23'h000000

`endif

/* verilog/trig_pkg.sv */
// Types shared by the trigger debounce and sequence capture block
`default_nettype none

package trig_pkg;

    // Burst sequencer states, Gray coded along the path from ST_IDLE to ST_FRAME
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_DELAY = 3'h1,
        ST_FETCH = 3'h3,
        ST_LOAD  = 3'h2,
        ST_FRAME = 3'h6
    } seq_state_t;

endpackage : trig_pkg

`default_nettype wire

/* verilog/seq_table_mem.sv */
// Per-index exposure and gain table with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "trig_params.svh"

module seq_table_mem (
    input wire logic clk,
    // Write side
    input wire logic wr_en,
    input wire logic [`TBL_AW-1:0] wr_addr,
    input wire logic [`EXP_W+`GAIN_W-1:0] wr_data,
    // Read side
    input wire logic [`TBL_AW-1:0] rd_addr,
    output logic [`EXP_W+`GAIN_W-1:0] rd_data_q
);

    logic [`EXP_W+`GAIN_W-1:0] mem [`TBL_DEPTH];

    // Plain synchronous RAM, no reset so it maps to block memory
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end

endmodule : seq_table_mem
`default_nettype wire

/* verilog/trigger_debounce_sequence_capture.sv */
// Trigger line conditioning and hardware sequence burst capture
`timescale 1ns/10ps
`default_nettype none
`include "trig_params.svh"

module trigger_debounce_sequence_capture #(
    parameter int unsigned US_TICKS = `US_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Isolated lines
    input wire logic iso_in,
    output logic iso_out_q,
    // General line zero
    input wire logic general_line_zero_in,
    output logic general_line_zero_out_q,
    output logic general_line_zero_oe_n_q,
    // General line one
    input wire logic general_line_one_in,
    output logic general_line_one_out_q,
    output logic general_line_one_oe_n_q,
    // Line configuration
    input wire logic [1:0] line_dir_out,
    input wire logic [1:0] line_out_val,
    input wire logic [1:0] trig_src,
    input wire logic trig_falling,
    input wire logic [`DBC_W-1:0] debounce_us,
    input wire logic [`DLY_W-1:0] delay_us,
    // Burst configuration
    input wire logic [`BURST_W-1:0] burst_len,
    input wire logic [`TBL_AW:0] table_num,
    // Table write port
    input wire logic tbl_wr,
    input wire logic [`TBL_AW-1:0] tbl_addr,
    input wire logic [`EXP_W-1:0] tbl_exposure,
    input wire logic [`GAIN_W-1:0] tbl_gain,
    // Frame handshake with sensor timing
    input wire logic frame_done,
    output logic frame_start_q,
    output logic [`EXP_W-1:0] frame_exposure_q,
    output logic [`GAIN_W-1:0] frame_gain_q,
    output logic [`TBL_AW-1:0] frame_index_q,
    // Status
    output logic busy_q,
    output logic trig_accept_q,
    output logic trig_drop_q
);

    // Next table index with wrap on the programmed entry count
    function automatic logic [`TBL_AW-1:0] next_index(
        input logic [`TBL_AW-1:0] idx,
        input logic [`TBL_AW:0] num
    );
        logic [`TBL_AW:0] inc;
        inc = {1'b0, idx} + 5'h01;
        if (inc >= num) begin
            next_index = `IDX_RST;
        end else begin
            next_index = idx + 4'h1;
        end
    endfunction : next_index

    // Prescaler step: wraps at one microsecond
    function automatic logic [`PRE_W-1:0] pre_step(input logic [`PRE_W-1:0] p);
        if (p >= US_TICKS[`PRE_W-1:0] - 8'h01) begin
            pre_step = 8'h00;
        end else begin
            pre_step = p + 8'h01;
        end
    endfunction : pre_step

    trig_pkg::seq_state_t state_q;
    logic [2:0] iso_s1_q, iso_s2_q;
    logic sel_level, sel_valid, act;
    logic armed_q;
    logic [`PRE_W-1:0] dbc_pre_q, dly_pre_q;
    logic [`DBC_W-1:0] dbc_cnt_q, dbc_lim;
    logic [`DLY_W-1:0] dly_cnt_q, dly_lim;
    logic accept;
    logic [`BURST_W-1:0] frame_cnt_q;
    logic [`TBL_AW-1:0] index_q;
    logic [`EXP_W+`GAIN_W-1:0] rd_data_q;

    seq_table_mem seq_table_mem_i (
        .clk(clk),
        .wr_en(tbl_wr),
        .wr_addr(tbl_addr),
        .wr_data({tbl_exposure, tbl_gain}),
        .rd_addr(index_q),
        .rd_data_q(rd_data_q)
    );

    // Two-stage synchronisers for the three input pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            iso_s1_q <= 3'h0;
            iso_s2_q <= 3'h0;
        end else begin
            iso_s1_q <= {general_line_one_in, general_line_zero_in, iso_in};
            iso_s2_q <= iso_s1_q;
        end
    end

    always_comb begin
        sel_level = 1'b0;
        sel_valid = 1'b0;
        case (trig_src)
            `SRC_ISO: begin
                sel_level = iso_s2_q[0];
                sel_valid = 1'b1;
            end
            `SRC_GL0: begin
                sel_level = iso_s2_q[1];
                sel_valid = ~line_dir_out[0];
            end
            `SRC_GL1: begin
                sel_level = iso_s2_q[2];
                sel_valid = ~line_dir_out[1];
            end
            default: begin
                sel_level = 1'b0;
                sel_valid = 1'b0;
            end
        endcase
    end

    // polarity picks rising or falling activation
    assign act = sel_valid & (sel_level ^ trig_falling);

    assign dbc_lim = (debounce_us > `DEBOUNCE_MAX_US) ? `DBC_W'(`DEBOUNCE_MAX_US) : debounce_us;
    assign dly_lim = (delay_us > `DELAY_MAX_US) ? `DLY_W'(`DELAY_MAX_US) : delay_us;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dbc_pre_q <= 8'h00;
            dbc_cnt_q <= `DBC_CNT_RST;
        end else if (!act) begin
            dbc_pre_q <= 8'h00;
            dbc_cnt_q <= `DBC_CNT_RST;
        end else begin
            dbc_pre_q <= pre_step(dbc_pre_q);
            // Saturate just past the clamped limit dbc_lim
            if (dbc_pre_q == US_TICKS[`PRE_W-1:0] - 8'h01 && dbc_cnt_q <= dbc_lim) begin
                dbc_cnt_q <= dbc_cnt_q + 15'h0001;
            end
        end
    end

    assign accept = armed_q & act & (dbc_cnt_q > dbc_lim);

    // Edge arming: a line held active fires only once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (!act) begin
            armed_q <= 1'b1;
        end else if (accept) begin
            armed_q <= 1'b0;
        end
    end

    // Burst sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= trig_pkg::ST_IDLE;
        end else begin
            case (state_q)
                trig_pkg::ST_IDLE: begin
                    if (accept && burst_len != 8'h00) begin
                        state_q <= trig_pkg::ST_DELAY;
                    end
                end
                trig_pkg::ST_DELAY: begin
                    if (dly_cnt_q >= dly_lim) begin
                        state_q <= trig_pkg::ST_FETCH;
                    end
                end
                trig_pkg::ST_FETCH: begin
                    state_q <= trig_pkg::ST_LOAD;
                end
                trig_pkg::ST_LOAD: begin
                    state_q <= trig_pkg::ST_FRAME;
                end
                trig_pkg::ST_FRAME: begin
                    if (frame_done) begin
                        if (frame_cnt_q >= burst_len - 8'h01) begin
                            state_q <= trig_pkg::ST_IDLE;
                        end else begin
                            state_q <= trig_pkg::ST_FETCH;
                        end
                    end
                end
                default: begin
                    state_q <= trig_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Trigger delay counter in microseconds
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dly_pre_q <= 8'h00;
            dly_cnt_q <= `DLY_CNT_RST;
        end else if (state_q != trig_pkg::ST_DELAY) begin
            dly_pre_q <= 8'h00;
            dly_cnt_q <= `DLY_CNT_RST;
        end else begin
            dly_pre_q <= pre_step(dly_pre_q);
            if (dly_pre_q == US_TICKS[`PRE_W-1:0] - 8'h01) begin
                dly_cnt_q <= dly_cnt_q + 23'h000001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_cnt_q <= 8'h00;
        end else if (state_q == trig_pkg::ST_IDLE) begin
            frame_cnt_q <= 8'h00;
        end else if (state_q == trig_pkg::ST_FRAME && frame_done) begin
            frame_cnt_q <= frame_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            index_q <= `IDX_RST;
        end else if (state_q == trig_pkg::ST_FRAME && frame_done) begin
            index_q <= next_index(index_q, table_num);
        end else if ({1'b0, index_q} >= table_num && state_q == trig_pkg::ST_IDLE) begin
            // Table shrunk below the current index
            index_q <= `IDX_RST;
        end
    end

    // frame takes its entry's exposure and gain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_start_q <= 1'b0;
            frame_exposure_q <= 24'h000000;
            frame_gain_q <= 16'h0000;
            frame_index_q <= `IDX_RST;
        end else begin
            frame_start_q <= (state_q == trig_pkg::ST_LOAD);
            if (state_q == trig_pkg::ST_LOAD) begin
                frame_exposure_q <= rd_data_q[`EXP_W+`GAIN_W-1:`GAIN_W];
                frame_gain_q <= rd_data_q[`GAIN_W-1:0];
                frame_index_q <= index_q;
            end
        end
    end

    // Status pulses and busy level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            trig_accept_q <= 1'b0;
            trig_drop_q <= 1'b0;
        end else begin
            busy_q <= (state_q != trig_pkg::ST_IDLE);
            trig_accept_q <= accept && state_q == trig_pkg::ST_IDLE && burst_len != 8'h00;
            trig_drop_q <= accept && state_q != trig_pkg::ST_IDLE;
        end
    end

    // line directions; isolated output always driven
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            iso_out_q <= 1'b0;
            general_line_zero_out_q <= 1'b0;
            general_line_one_out_q <= 1'b0;
            general_line_zero_oe_n_q <= 1'b1;
            general_line_one_oe_n_q <= 1'b1;
        end else begin
            // Busy shown so equipment can hold off triggers
            iso_out_q <= (state_q != trig_pkg::ST_IDLE);
            general_line_zero_out_q <= line_out_val[0];
            general_line_one_out_q <= line_out_val[1];
            general_line_zero_oe_n_q <= ~line_dir_out[0];
            general_line_one_oe_n_q <= ~line_dir_out[1];
        end
    end

endmodule : trigger_debounce_sequence_capture
`default_nettype wire

/* test/trig_capture_monitor.sv */
// Port checks for the trigger and burst capture block
`timescale 1ns/10ps
`default_nettype none
`include "trig_params.svh"

module trig_capture_monitor #(
    parameter int unsigned US_TICKS = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched ports
    input wire logic [1:0] line_dir_out,
    input wire logic [`DLY_W-1:0] delay_us,
    input wire logic iso_out_q,
    input wire logic general_line_zero_oe_n_q,
    input wire logic general_line_one_oe_n_q,
    input wire logic frame_start_q,
    input wire logic [`EXP_W-1:0] frame_exposure_q,
    input wire logic [`GAIN_W-1:0] frame_gain_q,
    input wire logic [`TBL_AW-1:0] frame_index_q,
    input wire logic busy_q,
    input wire logic trig_accept_q,
    input wire logic trig_drop_q
);
    // One clock domain, so one default for all checks
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    busy_on_iso_a: assert property (iso_out_q == busy_q)
        else $error("isolated output differs from busy");
    zero_dir_a: assert property (1 |=> general_line_zero_oe_n_q == !$past(line_dir_out[0]))
        else $error("line zero enable wrong");
    one_dir_a: assert property (1 |=> general_line_one_oe_n_q == !$past(line_dir_out[1]))
        else $error("line one enable wrong");
    accept_pulse_a: assert property (trig_accept_q |=> !trig_accept_q)
        else $error("accept pulse too long");
    accept_busy_a: assert property (trig_accept_q |=> busy_q)
        else $error("no burst after accept");
    drop_busy_a: assert property (trig_drop_q |-> busy_q && !trig_accept_q)
        else $error("drop outside a burst");
    start_busy_a: assert property (frame_start_q |-> busy_q)
        else $error("frame outside a burst");
    frame_hold_a: assert property (!frame_start_q |-> $stable(frame_exposure_q)
        && $stable(frame_gain_q) && $stable(frame_index_q)) else $error("frame data moved");
    start_gap_a: assert property (frame_start_q |=> !frame_start_q [*2])
        else $error("frames too close");
    zero_delay_a: assert property (trig_accept_q && delay_us == 0 |-> ##3 frame_start_q)
        else $error("zero delay start late");
endmodule : trig_capture_monitor

bind trigger_debounce_sequence_capture trig_capture_monitor #(.US_TICKS(US_TICKS))
    trig_capture_monitor_i (
        .clk(clk),
        .resetn(resetn),
        .line_dir_out(line_dir_out),
        .delay_us(delay_us),
        .iso_out_q(iso_out_q),
        .general_line_zero_oe_n_q(general_line_zero_oe_n_q),
        .general_line_one_oe_n_q(general_line_one_oe_n_q),
        .frame_start_q(frame_start_q),
        .frame_exposure_q(frame_exposure_q),
        .frame_gain_q(frame_gain_q),
        .frame_index_q(frame_index_q),
        .busy_q(busy_q),
        .trig_accept_q(trig_accept_q),
        .trig_drop_q(trig_drop_q)
    );
`default_nettype wire

/* test/ext_equipment.sv */
// Outside equipment: trigger pulse source and sensor frame timing
`timescale 1ns/10ps
`default_nettype none

module ext_equipment (
    // Clock
    input wire logic clk,
    // Pulse request
    input wire logic pulse_go,
    input wire logic [7:0] pulse_w,
    input wire logic [1:0] pulse_sel,
    input wire logic idle_lvl,
    // Sensor timing
    input wire logic frame_start_q,
    input wire logic [7:0] done_wait,
    // Driven lines
    output logic iso,
    output logic gl0,
    output logic gl1,
    output logic frame_done
);
    logic [7:0] left_q = 8'h00;
    logic [7:0] done_q = 8'h00;
    // pulse held for the requested width
    always @(posedge clk) begin
        if (pulse_go)
            left_q <= pulse_w;
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    // Frame ends a set time after it starts
    always @(posedge clk) begin
        if (frame_start_q)
            done_q <= done_wait;
        else if (done_q != 8'h00)
            done_q <= done_q - 8'h01;
    end
    assign frame_done = (done_q == 8'h01);
    // Only the selected line leaves its idle level
    assign iso = (pulse_sel == 2'h0 && left_q != 8'h00) ? !idle_lvl : idle_lvl;
    assign gl0 = (pulse_sel == 2'h1 && left_q != 8'h00) ? !idle_lvl : idle_lvl;
    assign gl1 = (pulse_sel == 2'h2 && left_q != 8'h00) ? !idle_lvl : idle_lvl;
endmodule : ext_equipment
`default_nettype wire

/* test/trigger_debounce_sequence_capture_test.sv */
// Self-checking bench for trigger debounce and burst capture
`timescale 1ns/10ps
`default_nettype none
`include "trig_params.svh"

module trigger_debounce_sequence_capture_test;
    logic clk = 1'b0, resetn = 1'b0, go = 1'b0, idle = 1'b0, falling = 1'b0, wr = 1'b0;
    logic [7:0] pw = 8'h00, dw = 8'h0a;
    logic [1:0] sel = 2'h0, src = 2'h0, dir = 2'h0, oval = 2'h0;
    logic [3:0] wa = 4'h0;
    logic [23:0] we = 24'h0, s_exp[16];
    logic [15:0] wg = 16'h0, s_gain[16];
    logic [22:0] dly = 23'h0;
    logic [7:0] blen = 8'h03;
    logic [4:0] tnum = 5'h05;
    logic iso, gl0, gl1, fdone, iso_o, o0, oe0, o1, oe1, fst, busy, acc, drp;
    logic [23:0] fexp;
    logic [15:0] fgain;
    logic [3:0] fidx;
    logic [43:0] exp_q[$];
    int fail_count = 0, n_tests = 0, seed = 32'h02dc8dad, idx = 0, r, i, accepts = 0, drops = 0;
    int e_acc = 0, e_drp = 0, since = 0, first = 0;
    // Wire level of each general line from both drivers
    wire logic w0 = oe0 ? gl0 : o0;
    wire logic w1 = oe1 ? gl1 : o1;

    always #25 clk = ~clk;

    trigger_debounce_sequence_capture #(.US_TICKS(2)) trigger_debounce_sequence_capture_i (
        .clk(clk), .resetn(resetn), .iso_in(iso), .iso_out_q(iso_o),
        .general_line_zero_in(w0), .general_line_zero_out_q(o0), .general_line_zero_oe_n_q(oe0),
        .general_line_one_in(w1), .general_line_one_out_q(o1), .general_line_one_oe_n_q(oe1),
        .line_dir_out(dir), .line_out_val(oval), .trig_src(src), .trig_falling(falling),
        .debounce_us(15'h0002), .delay_us(dly), .burst_len(blen), .table_num(tnum),
        .tbl_wr(wr), .tbl_addr(wa), .tbl_exposure(we), .tbl_gain(wg), .frame_done(fdone),
        .frame_start_q(fst), .frame_exposure_q(fexp), .frame_gain_q(fgain),
        .frame_index_q(fidx), .busy_q(busy), .trig_accept_q(acc), .trig_drop_q(drp));

    ext_equipment ext_equipment_i (.clk(clk), .pulse_go(go), .pulse_w(pw), .pulse_sel(sel),
        .idle_lvl(idle), .frame_start_q(fst), .done_wait(dw), .iso(iso), .gl0(gl0),
        .gl1(gl1), .frame_done(fdone));

    task automatic check(input string name, input logic [43:0] e, input logic [43:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", name, e, g);
            fail_count++;
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // Queue the burst's entries, pulse the line, wait out the burst
    task automatic fire(input string name, input logic [1:0] s, input logic [7:0] w, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            exp_q.push_back({idx[3:0], s_exp[idx], s_gain[idx]});
            idx = (idx + 1) % tnum;
        end
        e_acc += (n > 0);
        sel <= s;
        pw <= w;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 60 && busy !== 1'b1; k++) @(posedge clk);
        for (k = 0; busy === 1'b1; k++) begin
            if (k > 3000) begin
                fail_count++;
                summarize();
            end
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        check("accepts", e_acc, accepts);
        check("drops", e_drp, drops);
        $display("test %s done", name);
    endtask : fire

    // Watch outputs and compare each frame with the oldest note
    always @(posedge clk) begin
        since++;
        if (acc === 1'b1) begin
            accepts++;
            since = 0;
            first = 1;
        end
        if (drp === 1'b1)
            drops++;
        if (fst === 1'b1) begin
            // first start: 3 pipeline cycles plus 2 cycles per microsecond
            if (first == 1) check("delay", 3 + 2 * dly, since);
            first = 0;
            if (exp_q.size() == 0) check("extra frame", 0, 1);
            else check("frame", exp_q.pop_front(), {fidx, fexp, fgain});
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        check("oe in reset", 2'b11, {oe1, oe0});
        resetn <= 1'b1;
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            s_exp[i] = r[23:0];
            r = $random(seed);
            s_gain[i] = r[15:0];
            wr <= 1'b1;
            wa <= i[3:0];
            we <= s_exp[i];
            wg <= s_gain[i];
            @(posedge clk);
        end
        wr <= 1'b0;
        fire("short", 2'h0, 8'h04, 0);
        fire("first", 2'h0, 8'h0c, 3);
        fire("wrap", 2'h0, 8'h0c, 3);
        dw <= 8'h3c;
        e_drp = 1;
        fork
            fire("busy", 2'h0, 8'h0c, 3);
            begin
                repeat (40) @(posedge clk);
                go <= 1'b1;
                @(posedge clk);
                go <= 1'b0;
            end
        join
        dw <= 8'h0a;
        dly <= 23'h3;
        fire("delay", 2'h0, 8'h0c, 3);
        dly <= 23'h0;
        falling <= 1'b1;
        idle <= 1'b1;
        repeat (8) @(posedge clk);
        fire("falling", 2'h0, 8'h0c, 3);
        blen <= 8'h05;
        fire("five", 2'h0, 8'h0c, 5);
        blen <= 8'h00;
        fire("no frames", 2'h0, 8'h0c, 0);
        blen <= 8'h03;
        src <= 2'h1;
        fire("line zero", 2'h1, 8'h0c, 3);
        dir <= 2'b01;
        oval <= 2'b10;
        fire("line out", 2'h1, 8'h0c, 0);
        check("line drive", 4'b1010, {oe1, oe0, o1, o0});
        summarize();
    end
endmodule : trigger_debounce_sequence_capture_test
`default_nettype wire
